// ---- hsp_pkg.sv ----
package hsp_pkg;
    // clock and character timing
    localparam int CLK_HZ = 100_000_000;
    localparam int BAUD_DEF = 115_200;
    localparam int BAUD_DIV_DEF = CLK_HZ / BAUD_DEF;
    localparam int CHAR_BITS = 10;
    localparam logic [3:0] BIT_START = 4'h0;
    localparam logic [3:0] BIT_STOP = 4'h9;
    localparam logic [2:0] SPI_LAST_BIT = 3'h7;
    // buffers and packets
    localparam int FIFO_DEPTH_DEF = 128;
    localparam int MAX_PKT_DEF = 256;
    localparam int CTS_HYST = 17;
    localparam logic [7:0] SPI_FILLER = 8'hff;
    localparam logic [1:0] ESC_COUNT = 2'h3;
    localparam logic [7:0] IDLE_SAT = 8'hff;
    // settings encodings
    localparam logic [2:0] SM_PIN_SLEEP = 3'h1;
    localparam logic [1:0] FRAME_TRANSPARENT = 2'h0;
    // serial port selection, gray along init -> open -> uart
    typedef enum logic [1:0] {
        P_INIT = 2'b00,
        P_OPEN = 2'b01,
        P_UART = 2'b11,
        P_SPI = 2'b10
    } hsp_port_type;
endpackage : hsp_pkg

// ---- hsp_sync.sv ----
`timescale 1ns/100ps
module hsp_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] INIT = '0
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rstn,
    // levels
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } hsp_sync_type;

    hsp_sync_type r_reg;
    hsp_sync_type r_next;

    always_comb begin
        r_next.s1 = d;
        r_next.s2 = r_reg.s1;
    end

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            r_reg <= {INIT, INIT};
        end else begin
            r_reg <= r_next;
        end
    end

    assign q = r_reg.s2;
endmodule : hsp_sync

// ---- hsp_mem.sv ----
`timescale 1ns/100ps
module hsp_mem #(
    parameter int W = 8,
    parameter int DEPTH = 128,
    localparam int AW = $clog2(DEPTH),
    localparam int LW = $clog2(DEPTH + 2)
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rstn,
    // write side
    input wire logic wr_valid,
    input wire logic [W-1:0] wr_data,
    output logic wr_ready,
    // read side
    output logic rd_valid,
    output logic [W-1:0] rd_data,
    input wire logic rd_ready,
    // occupancy including the output register
    output logic [LW-1:0] level
);
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
        $error("hsp_mem depth must be a power of two");
    end

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [LW-1:0] cnt;
        logic ov;
        logic [W-1:0] od;
    } hsp_mem_type;

    hsp_mem_type r_reg;
    hsp_mem_type r_next;
    logic push;
    logic fill;

    always_comb begin
        r_next = r_reg;
        push = wr_valid && (r_reg.cnt != LW'(DEPTH));
        fill = (r_reg.cnt != '0) && (!r_reg.ov || rd_ready);
        if (push) begin
            r_next.mem[r_reg.wp] = wr_data;
            r_next.wp = r_reg.wp + 1'b1;
        end
        if (fill) begin
            r_next.od = r_reg.mem[r_reg.rp];
            r_next.rp = r_reg.rp + 1'b1;
            r_next.ov = 1'b1;
        end else if (rd_ready) begin
            r_next.ov = 1'b0;
        end
        r_next.cnt = LW'(r_reg.cnt + LW'(push) - LW'(fill));
    end

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end

    assign wr_ready = (r_reg.cnt != LW'(DEPTH));
    assign rd_valid = r_reg.ov;
    assign rd_data = r_reg.od;
    assign level = LW'(r_reg.cnt + LW'(r_reg.ov));
endmodule : hsp_mem

// ---- hsp_top.sv ----
`timescale 1ns/100ps
// Behaviour
// R1 - spi carries unescaped frames only, framing uart-only
// R2 - slave output always shifts a byte
// R3 - both directions may carry valid data together
// R4 - sleep pin governs pin sleep by default
// R5 - else select low wakes, high sleeps
// R6 - neither pin usable: stay awake always
// R7 - both enabled: output on uart until spi input
// R8 - first port with input locks until reset
// R9 - single enabled port used exclusively
// R10 - both disabled falls back to uart
// R11 - spi mode 0, msb first
// R12 - receive buffer drops bytes on overflow
// R13 - master paces frames, no spi flow control
// R14 - rf packet that does not fit dropped whole
// R15 - cts rises near full, falls 17 lower
// R16 - rts high holds back uart output
// R17 - data present line low while uart data queued
// R18 - transparent packet closes on timeout, escape, length
// R19 - ports usable only with pins as peripherals; the code still selects uart when neither port's pins are peripherals (R10)
// R20 - attention low while spi data queued
// R21 - uart character start, 8 lsb-first, stop
// R22 - master clock at most 6 Mb/s
// R23 - filler byte on slave output when idle
module hsp_top
    import hsp_pkg::*;
#(
    parameter int BAUD_DIV = BAUD_DIV_DEF,
    parameter int DEPTH = FIFO_DEPTH_DEF,
    parameter int MAX_PKT = MAX_PKT_DEF,
    localparam int LW = $clog2(DEPTH + 2)
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rstn,
    // uart pins
    input wire logic uart_rxd,
    output logic uart_txd,
    input wire logic uart_rts,
    output logic cts_pin,
    output logic data_present_line,
    // spi pins
    input wire logic spi_sclk,
    input wire logic spi_mosi,
    input wire logic spi_ssel_n,
    output logic spi_miso,
    output logic spi_miso_oe,
    output logic host_attention_n,
    // sleep
    input wire logic sleep_pin_line,
    output logic sleep_out,
    // configuration
    input wire logic uart_pins_periph,
    input wire logic spi_pins_periph,
    input wire logic sleep_pin_periph,
    input wire logic [2:0] sleep_mode_setting,
    input wire logic [1:0] framing_mode_setting,
    input wire logic cts_enable_setting,
    input wire logic rts_enable_setting,
    input wire logic data_present_enable,
    input wire logic [LW-1:0] flow_threshold,
    input wire logic [7:0] packetization_timeout,
    input wire logic [7:0] escape_guard_time,
    input wire logic [7:0] escape_character,
    // receive stream to the core
    output logic rx_valid,
    output logic [7:0] rx_data,
    input wire logic rx_ready,
    output logic rx_lost,
    output logic pkt_close,
    // transmit stream from the core
    input wire logic tx_valid,
    input wire logic [7:0] tx_data,
    output logic tx_ready,
    input wire logic rf_pkt_start,
    input wire logic [LW-1:0] rf_pkt_len,
    // status
    output logic [1:0] active_port
);
    localparam int CHAR_CYC = BAUD_DIV * CHAR_BITS;
    localparam int BW = $clog2(CHAR_CYC + 1);
    localparam int PW = $clog2(MAX_PKT + 1);

    if (BAUD_DIV < 4 || CHAR_CYC > 65535 || MAX_PKT < 1) begin : g_bad_param
        $error("hsp_top parameters out of range");
    end

    typedef struct packed {
        hsp_port_type port;
        logic sck_q;
        logic ssel_q;
        logic [7:0] si_sh;
        logic [2:0] si_cnt;
        logic [7:0] so_sh;
        logic so_real;
        logic moe;
        logic rx_busy;
        logic [BW-1:0] rx_cnt;
        logic [3:0] rx_bit;
        logic [7:0] rx_sh;
        logic rxw_v;
        logic [7:0] rxw_d;
        logic tx_busy;
        logic [BW-1:0] tx_cnt;
        logic [3:0] tx_bit;
        logic [8:0] tx_sh;
        logic txo_n;
        logic drop;
        logic lost;
        logic cts;
        logic dp;
        logic att;
        logic sleep;
        logic [BW-1:0] idle_cyc;
        logic [7:0] idle_ch;
        logic [1:0] esc_n;
        logic [PW-1:0] pkt_n;
        logic close;
    } hsp_top_type;

    hsp_top_type r_reg;
    hsp_top_type r_next;

    logic rxd_s, rts_s, sclk_s, mosi_s, ssel_s, slp_s;
    logic rxf_wr_ready, txf_wr_ready, txf_rd_valid, tx_pop, drop_now;
    logic [7:0] txf_rd_data;
    logic [LW-1:0] rxf_level, txf_level;
    logic sel_fall, sck_rise, sck_fall, rx_start, uart_ok, transp, tick;

    hsp_sync #(.W(6), .INIT(6'h22)) u_sync (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .d({uart_rxd, uart_rts, spi_sclk, spi_mosi, spi_ssel_n, sleep_pin_line}),
        .q({rxd_s, rts_s, sclk_s, mosi_s, ssel_s, slp_s})
    );

    hsp_mem #(.W(8), .DEPTH(DEPTH)) u_rxf (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .wr_valid(r_reg.rxw_v),
        .wr_data(r_reg.rxw_d),
        .wr_ready(rxf_wr_ready),
        .rd_valid(rx_valid),
        .rd_data(rx_data),
        .rd_ready(rx_ready),
        .level(rxf_level)
    );

    hsp_mem #(.W(8), .DEPTH(DEPTH)) u_txf (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .wr_valid(tx_valid && !drop_now),
        .wr_data(tx_data),
        .wr_ready(txf_wr_ready),
        .rd_valid(txf_rd_valid),
        .rd_data(txf_rd_data),
        .rd_ready(tx_pop),
        .level(txf_level)
    );

    // whole-packet admission into the transmit buffer
    assign drop_now = rf_pkt_start ? (LW'(DEPTH + 1) - txf_level < rf_pkt_len) : r_reg.drop; // R14
    assign tx_ready = drop_now || txf_wr_ready;

    assign sel_fall = !ssel_s && r_reg.ssel_q;
    assign sck_rise = sclk_s && !r_reg.sck_q;
    assign sck_fall = !sclk_s && r_reg.sck_q;
    assign uart_ok = (r_reg.port == P_UART) || (r_reg.port == P_OPEN && !sel_fall);
    assign rx_start = !r_reg.rx_busy && !rxd_s && uart_ok;
    assign transp = (r_reg.port == P_UART) && (framing_mode_setting == FRAME_TRANSPARENT); // R1
    assign tick = (r_reg.idle_cyc == BW'(CHAR_CYC - 1));

    always_comb begin
        r_next = r_reg;
        tx_pop = 1'b0;
        r_next.rxw_v = 1'b0;
        r_next.close = 1'b0;
        r_next.drop = drop_now;
        r_next.lost = r_reg.rxw_v && !rxf_wr_ready; // R12
        r_next.sck_q = sclk_s;
        r_next.ssel_q = ssel_s;
        r_next.idle_cyc = tick ? '0 : BW'(r_reg.idle_cyc + 1'b1);
        if (tick && r_reg.idle_ch != IDLE_SAT) begin
            r_next.idle_ch = r_reg.idle_ch + 1'b1;
        end
        // port selection
        case (r_reg.port)
            P_INIT: begin // R19
                if (uart_pins_periph && spi_pins_periph) begin
                    r_next.port = P_OPEN;
                end else if (spi_pins_periph) begin // R9
                    r_next.port = P_SPI;
                end else begin // R10
                    r_next.port = P_UART;
                end
            end
            P_OPEN: begin // R8
                if (sel_fall) begin
                    r_next.port = P_SPI;
                end else if (rx_start) begin
                    r_next.port = P_UART;
                end
            end
            default: r_next.port = r_reg.port;
        endcase
        // uart receive, start, 8 data lsb first, stop
        if (r_reg.rx_busy) begin // R21
            if (r_reg.rx_cnt != '0) begin
                r_next.rx_cnt = r_reg.rx_cnt - 1'b1;
            end else begin
                r_next.rx_cnt = BW'(BAUD_DIV - 1);
                r_next.rx_bit = r_reg.rx_bit + 1'b1;
                if (r_reg.rx_bit == BIT_START && rxd_s) begin
                    r_next.rx_busy = 1'b0;
                end else if (r_reg.rx_bit == BIT_STOP) begin
                    r_next.rx_busy = 1'b0;
                    if (rxd_s && r_reg.port != P_SPI) begin // R12
                        r_next.rxw_v = 1'b1;
                        r_next.rxw_d = r_reg.rx_sh;
                    end
                end else if (r_reg.rx_bit != BIT_START) begin
                    r_next.rx_sh = {rxd_s, r_reg.rx_sh[7:1]};
                end
            end
        end else if (rx_start) begin
            r_next.rx_busy = 1'b1;
            r_next.rx_cnt = BW'(BAUD_DIV / 2);
            r_next.rx_bit = BIT_START;
        end
        // transparent packetization
        if (transp && r_next.rxw_v) begin // R18
            r_next.idle_cyc = '0;
            r_next.idle_ch = '0;
            r_next.pkt_n = PW'(r_reg.pkt_n + 1'b1);
            if (r_reg.rx_sh == escape_character && r_reg.esc_n != ESC_COUNT
                && (r_reg.esc_n != '0 || r_reg.idle_ch >= escape_guard_time)) begin
                r_next.esc_n = r_reg.esc_n + 1'b1;
            end else begin
                r_next.esc_n = '0;
            end
            if (packetization_timeout == '0 || r_reg.pkt_n == PW'(MAX_PKT - 1)) begin
                r_next.close = 1'b1;
                r_next.pkt_n = '0;
            end
        end else if (transp && tick) begin // R18
            if (r_reg.esc_n == ESC_COUNT && r_next.idle_ch == escape_guard_time) begin
                r_next.close = 1'b1;
                r_next.esc_n = '0;
                r_next.pkt_n = '0;
            end else if (r_reg.pkt_n != '0 && r_next.idle_ch == packetization_timeout) begin
                r_next.close = 1'b1;
                r_next.pkt_n = '0;
            end
        end
        // uart transmit
        if (!uart_ok) begin // R8
            r_next.tx_busy = 1'b0;
            r_next.txo_n = 1'b0;
        end else if (r_reg.tx_busy) begin // R21
            if (r_reg.tx_cnt != '0) begin
                r_next.tx_cnt = r_reg.tx_cnt - 1'b1;
            end else if (r_reg.tx_bit == BIT_STOP) begin
                r_next.tx_busy = 1'b0;
                r_next.txo_n = 1'b0;
            end else begin
                r_next.tx_cnt = BW'(BAUD_DIV - 1);
                r_next.txo_n = !r_reg.tx_sh[0];
                r_next.tx_sh = {1'b0, r_reg.tx_sh[8:1]};
                r_next.tx_bit = r_reg.tx_bit + 1'b1;
            end
        end else if (txf_rd_valid && !(rts_enable_setting && rts_s)) begin // R7 R16
            tx_pop = 1'b1;
            r_next.tx_busy = 1'b1;
            r_next.txo_n = 1'b1;
            r_next.tx_sh = {1'b1, txf_rd_data};
            r_next.tx_cnt = BW'(BAUD_DIV - 1);
            r_next.tx_bit = BIT_START;
        end
        // spi slave, mode 0, msb first, full duplex
        r_next.moe = 1'b0;
        if (r_reg.port == P_SPI || (r_reg.port == P_OPEN && sel_fall)) begin
            r_next.moe = !ssel_s;
            if (ssel_s) begin
                r_next.si_cnt = '0;
            end else if (sck_rise) begin // R11 R3
                r_next.si_sh = {r_reg.si_sh[6:0], mosi_s};
                r_next.si_cnt = r_reg.si_cnt + 1'b1;
                if (r_reg.si_cnt == SPI_LAST_BIT) begin // R1 R12
                    r_next.rxw_v = 1'b1;
                    r_next.rxw_d = {r_reg.si_sh[6:0], mosi_s};
                end
            end else if (sel_fall || (sck_fall && r_reg.si_cnt == '0)) begin // R2
                r_next.si_cnt = '0;
                if (txf_rd_valid) begin
                    tx_pop = 1'b1;
                    r_next.so_sh = txf_rd_data;
                    r_next.so_real = 1'b1;
                end else begin // R23
                    r_next.so_sh = SPI_FILLER;
                    r_next.so_real = 1'b0;
                end
            end else if (sck_fall) begin // R11
                r_next.so_sh = {r_reg.so_sh[6:0], 1'b0};
            end
        end
        // indicators
        r_next.att = (r_reg.port == P_SPI) && (txf_level != '0 || r_next.so_real); // R20
        r_next.dp = data_present_enable && (r_reg.port != P_SPI) && (txf_level != '0); // R17
        if (!cts_enable_setting || r_reg.port == P_SPI) begin
            r_next.cts = 1'b0;
        end else if (rxf_level >= flow_threshold) begin // R15
            r_next.cts = 1'b1;
        end else if ({1'b0, rxf_level} + (LW + 1)'(CTS_HYST) <= {1'b0, flow_threshold}) begin // R15
            r_next.cts = 1'b0;
        end
        // pin sleep
        if (sleep_mode_setting != SM_PIN_SLEEP) begin
            r_next.sleep = 1'b0;
        end else if (sleep_pin_periph) begin // R4
            r_next.sleep = slp_s;
        end else if (spi_pins_periph) begin // R5
            r_next.sleep = ssel_s;
        end else begin // R6
            r_next.sleep = 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            r_reg <= '0;
            r_reg.ssel_q <= 1'b1;
        end else begin
            r_reg <= r_next;
        end
    end

    assign uart_txd = !r_reg.txo_n;
    assign cts_pin = r_reg.cts;
    assign data_present_line = !r_reg.dp;
    assign spi_miso = r_reg.so_sh[7];
    assign spi_miso_oe = r_reg.moe;
    assign host_attention_n = !r_reg.att;
    assign sleep_out = r_reg.sleep;
    assign rx_lost = r_reg.lost;
    assign pkt_close = r_reg.close;
    assign active_port = r_reg.port;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);

    a_port_lock: assert property ((r_reg.port == P_UART || r_reg.port == P_SPI) |=> // R8
        $stable(r_reg.port)) else $error("locked port changed");
    a_spi_mutes_uart: assert property (r_reg.port == P_SPI |=> uart_txd [*3]) // R8
        else $error("uart driven while spi active");
    a_uart_only: assert property (r_reg.port == P_UART |-> !spi_miso_oe) // R9
        else $error("miso driven while uart active");
    a_both_off: assert property ((r_reg.port == P_INIT && !uart_pins_periph && !spi_pins_periph) |=> // R10
        r_reg.port == P_UART) else $error("no fallback to uart");
    a_cts_rise: assert property ((cts_enable_setting && r_reg.port != P_SPI && rxf_level >= flow_threshold) // R15
        |=> cts_pin) else $error("cts not raised");
    a_rts_hold: assert property ((rts_enable_setting && rts_s && !r_reg.tx_busy) |=> !r_reg.tx_busy) // R16
        else $error("char started under rts");
    a_attn_queued: assert property ((r_reg.port == P_SPI && txf_level != '0) |=> !host_attention_n) // R20
        else $error("attention not asserted");
    a_pkt_drop: assert property ((rf_pkt_start && LW'(DEPTH + 1) - txf_level < rf_pkt_len) // R14
        |-> tx_ready ##1 (r_reg.drop && tx_ready)) else $error("partial packet kept");
    a_rx_lost: assert property ((r_reg.rxw_v && !rxf_wr_ready) |=> rx_lost) // R12
        else $error("overflow not flagged");
    a_sleep_ssel: assert property ((sleep_mode_setting == SM_PIN_SLEEP && !sleep_pin_periph // R5
        && spi_pins_periph) |=> sleep_out == $past(ssel_s)) else $error("sleep not following select");
endmodule : hsp_top

// ---- hsp_host_model.sv ----
`timescale 1ns/100ps
module hsp_host_model #(
    parameter int BAUD_DIV = 8
) (
    // clock
    input wire logic clk_sys,
    // uart
    output logic uart_rxd,
    input wire logic uart_txd,
    // spi
    output logic spi_sclk,
    output logic spi_mosi,
    output logic spi_ssel_n,
    input wire logic spi_miso
);
    initial begin
        uart_rxd = 1'b1;
        spi_sclk = 1'b0;
        spi_mosi = 1'b1;
        spi_ssel_n = 1'b1;
    end
    task automatic wait_n(input int n);
        repeat (n) @(negedge clk_sys);
    endtask : wait_n
    // start low, 8 bits lsb first, stop high
    task automatic uart_send(input logic [7:0] b);
        logic [9:0] fr;
        fr = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            uart_rxd = fr[i];
            wait_n(BAUD_DIV);
        end
    endtask : uart_send
    task automatic uart_recv(input int lim, output logic [7:0] b, output bit ok);
        int n;
        n = 0;
        ok = 1'b0;
        b = 8'h00;
        while (uart_txd !== 1'b0 && n < lim) begin
            wait_n(1);
            n++;
        end
        if (n < lim) begin
            wait_n(BAUD_DIV / 2);
            for (int i = 0; i < 8; i++) begin
                wait_n(BAUD_DIV);
                b[i] = uart_txd;
            end
            wait_n(BAUD_DIV);
            ok = (uart_txd === 1'b1);
        end
    endtask : uart_recv
    // select changes, mosi scrambled while released
    task automatic sel(input logic v);
        spi_ssel_n = v;
        if (v) spi_mosi = ~spi_mosi;
        wait_n(8);
    endtask : sel
    // mode 0, msb first, 160 ns clock, gap after each byte
    task automatic spi_xfer(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            spi_mosi = tx[i];
            wait_n(8);
            spi_sclk = 1'b1;
            rx[i] = spi_miso;
            wait_n(8);
            spi_sclk = 1'b0;
        end
        wait_n(16);
    endtask : spi_xfer
endmodule : hsp_host_model

// ---- hsp_top_tb.sv ----
`timescale 1ns/100ps
module hsp_top_tb;
    import hsp_pkg::*;
    localparam int BD = 8;
    localparam int LV = 6;
    logic clk_sys = 1'b0;
    logic rstn = 1'b0;
    logic uart_rxd, uart_txd, uart_rts, cts_pin, data_present_line, fc, fr, dpe;
    logic spi_sclk, spi_mosi, spi_ssel_n, spi_miso, spi_miso_oe, host_attention_n, miso_wire;
    logic sleep_pin_line, sleep_out, uart_p, spi_p, sleep_p;
    logic rx_valid, rx_ready, rx_lost, pkt_close, tx_valid, tx_ready, pkt_start;
    logic [2:0] sm;
    logic [1:0] fm;
    logic [1:0] active_port;
    logic [LV-1:0] ft, pkt_len;
    logic [7:0] ro, tx_data, rx_data, b, m, got;
    logic [7:0] q[$];
    logic [31:0] seed = 32'h0000_acdd;
    bit ok;
    int num_errors = 0;
    int n_compared = 0;
    int lost_cnt = 0;
    int lowc;
    initial begin
        forever #5 clk_sys = ~clk_sys;
    end
    // pull-up when released
    assign miso_wire = (spi_miso_oe === 1'b1) ? spi_miso : 1'b1;
    always @(posedge clk_sys) begin
        if (rx_lost === 1'b1) lost_cnt <= lost_cnt + 1;
    end
    hsp_top #(.BAUD_DIV(BD), .DEPTH(32), .MAX_PKT(8)) dut (
        .clk_sys(clk_sys), .rstn(rstn), .uart_rxd(uart_rxd), .uart_txd(uart_txd), .uart_rts(uart_rts),
        .cts_pin(cts_pin), .data_present_line(data_present_line), .spi_sclk(spi_sclk), .spi_mosi(spi_mosi),
        .spi_ssel_n(spi_ssel_n), .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe),
        .host_attention_n(host_attention_n), .sleep_pin_line(sleep_pin_line), .sleep_out(sleep_out),
        .uart_pins_periph(uart_p), .spi_pins_periph(spi_p), .sleep_pin_periph(sleep_p),
        .sleep_mode_setting(sm), .framing_mode_setting(fm), .cts_enable_setting(fc), .rts_enable_setting(fr),
        .data_present_enable(dpe), .flow_threshold(ft), .packetization_timeout(ro),
        .escape_guard_time(8'h02), .escape_character(8'h2b), .rx_valid(rx_valid), .rx_data(rx_data),
        .rx_ready(rx_ready), .rx_lost(rx_lost), .pkt_close(pkt_close), .tx_valid(tx_valid),
        .tx_data(tx_data), .tx_ready(tx_ready), .rf_pkt_start(pkt_start), .rf_pkt_len(pkt_len),
        .active_port(active_port)
    );
    hsp_host_model #(.BAUD_DIV(BD)) host (
        .clk_sys(clk_sys), .uart_rxd(uart_rxd), .uart_txd(uart_txd), .spi_sclk(spi_sclk),
        .spi_mosi(spi_mosi), .spi_ssel_n(spi_ssel_n), .spi_miso(miso_wire)
    );
    function automatic logic [7:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed[7:0];
    endfunction : rnd
    function automatic logic [1:0] exp_port(input logic u, input logic s);
        if (u && s) return P_OPEN;
        return s ? P_SPI : P_UART;
    endfunction : exp_port
    function automatic logic pick(input int w);
        return (w == 0) ? rx_valid : pkt_close;
    endfunction : pick
    task automatic final_report();
        if (num_errors == 0 && n_compared > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : final_report
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] seen);
        n_compared++;
        if (seen !== exp) begin
            num_errors++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic cyc(input int n);
        repeat (n) @(negedge clk_sys);
    endtask : cyc
    task automatic wait_for(input int w, input int lim);
        int n;
        n = 0;
        while (pick(w) !== 1'b1) begin
            n++;
            if (n > lim) begin
                num_errors++;
                final_report();
            end
            cyc(1);
        end
    endtask : wait_for
    task automatic reset_dut(input logic u, input logic s, input logic sl);
        uart_p = u;
        spi_p = s;
        sleep_p = sl;
        rstn = 1'b0;
        cyc(2);
        rstn = 1'b1;
        cyc(4);
    endtask : reset_dut
    task automatic pop(input logic [7:0] exp);
        wait_for(0, 400);
        check("rx_data", exp, rx_data);
        rx_ready = 1'b1;
        cyc(1);
        rx_ready = 1'b0;
        cyc(3);
    endtask : pop
    task automatic send_tx(input logic [7:0] d, input logic [LV-1:0] len);
        pkt_start = 1'b1;
        pkt_len = len;
        tx_valid = 1'b1;
        tx_data = d;
        cyc(1);
        pkt_start = 1'b0;
        tx_valid = 1'b0;
        cyc(2);
    endtask : send_tx
    initial begin
        uart_rts = 1'b0;
        sleep_pin_line = 1'b0;
        sm = SM_PIN_SLEEP;
        fm = 2'h1;
        fc = 1'b1;
        fr = 1'b1;
        dpe = 1'b1;
        ft = 6'h14;
        ro = 8'h01;
        rx_ready = 1'b0;
        tx_valid = 1'b0;
        tx_data = 8'h00;
        pkt_start = 1'b0;
        pkt_len = '0;
        uart_p = 1'b1;
        spi_p = 1'b1;
        sleep_p = 1'b0;
        cyc(1);
        // port choice, idle pins, select-driven sleep
        for (int i = 0; i < 4; i++) begin
            reset_dut(i[0], i[1], 1'b0);
            check("active_port", exp_port(i[0], i[1]), active_port);
            check("idle_pins", 8'h16, {uart_txd, cts_pin, data_present_line, host_attention_n, spi_miso_oe});
            check("sleep_out", i[1], sleep_out);
            host.sel(1'b0);
            check("miso_oe", i[1], spi_miso_oe);
            check("sleep_out", 8'h00, sleep_out);
            host.sel(1'b1);
        end
        // sleep request pin
        reset_dut(1'b1, 1'b1, 1'b1);
        sleep_pin_line = 1'b1;
        cyc(6);
        check("sleep_out", 8'h01, sleep_out);
        sleep_pin_line = 1'b0;
        cyc(6);
        check("sleep_out", 8'h00, sleep_out);
        sm = 3'h0;
        sleep_pin_line = 1'b1;
        cyc(6);
        check("sleep_out", 8'h00, sleep_out);
        sleep_pin_line = 1'b0;
        sm = SM_PIN_SLEEP;
        // uart, rts hold back and data present
        fm = FRAME_TRANSPARENT;
        reset_dut(1'b1, 1'b0, 1'b0);
        uart_rts = 1'b1;
        cyc(4);
        b = rnd();
        send_tx(b, 6'h01);
        lowc = 0;
        repeat (BD * 30) begin
            cyc(1);
            if (uart_txd !== 1'b1) lowc++;
        end
        check("txd_held", 8'h00, lowc[7:0]);
        dpe = 1'b0;
        cyc(2);
        check("data_present", 8'h01, data_present_line);
        dpe = 1'b1;
        cyc(2);
        check("data_present", 8'h00, data_present_line);
        fr = 1'b0;
        host.uart_recv(200, got, ok);
        check("uart_tx", b, got);
        check("uart_stop", 8'h01, ok);
        fr = 1'b1;
        uart_rts = 1'b0;
        check("data_present", 8'h01, data_present_line);
        send_tx(rnd(), 6'h30);
        host.uart_recv(300, got, ok);
        check("packet_dropped", 8'h00, ok);
        // receive flood, cts hysteresis, overflow
        for (int i = 0; i < 34; i++) begin
            q.push_back(rnd());
            host.uart_send(q[i]);
            cyc(4);
            if (i == 18) check("cts", 8'h00, cts_pin);
            if (i == 19) check("cts", 8'h01, cts_pin);
        end
        check("rx_lost", 8'h01, lost_cnt[7:0]);
        for (int i = 0; i < 33; i++) begin
            pop(q[i]);
            if (i == 28) check("cts", 8'h01, cts_pin);
            if (i == 29) check("cts", 8'h00, cts_pin);
        end
        host.uart_send(rnd());
        wait_for(1, 400);
        check("pkt_close", 8'h01, pkt_close);
        ro = 8'h00;
        host.uart_send(rnd());
        wait_for(1, 20);
        check("pkt_close", 8'h01, pkt_close);
        // spi: filler, attention, full duplex
        fm = 2'h1;
        reset_dut(1'b1, 1'b1, 1'b0);
        host.sel(1'b0);
        check("active_port", P_SPI, active_port);
        b = rnd();
        send_tx(b, 6'h01);
        check("attention", 8'h00, host_attention_n);
        m = rnd();
        host.spi_xfer(m, got);
        check("filler", SPI_FILLER, got);
        pop(m);
        check("attention", 8'h00, host_attention_n);
        check("uart_txd", 8'h01, uart_txd);
        m = rnd();
        host.spi_xfer(m, got);
        check("miso", b, got);
        pop(m);
        check("attention", 8'h01, host_attention_n);
        host.sel(1'b1);
        final_report();
    end
endmodule : hsp_top_tb
